// *** shared/video_dac_defs.svh ***
// Offsets, field positions, reset values and timing counts of the video DAC front end.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef VIDEO_DAC_DEFS_SVH
`define VIDEO_DAC_DEFS_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define ADDR_W 4
`define OFS_CTRL 4'h0
`define OFS_SAMPLE 4'h4
`define OFS_STATUS 4'h8
`define OFS_COUNT 4'hc

// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define CTRL_W 7
`define CTRL_COMPOSITE 0
`define CTRL_SW_LOAD 1
`define CTRL_WHITE 2
`define CTRL_BLANK 3
`define CTRL_SYNC 4
`define CTRL_SET 5
`define CTRL_RESET 6
`define CTRL_RST_VAL 7'h01

// ---------------------------------------------------------------
// Status fields
// ---------------------------------------------------------------
`define ST_SYNC 8
`define ST_BLANK 9
`define ST_OVERRIDE 10
`define ST_CONFLICT 11
`define ST_RATE 12

// ---------------------------------------------------------------
// Sample coding, timing and bus response codes
// ---------------------------------------------------------------
`define CODE_W 8
`define CODE_WHITE 8'hff
`define CODE_FULL 8'h00
`define COUNT_W 16
`define CLK_MHZ 10
`define STROBE_MAX_ECL_MHZ 100
`define STROBE_MAX_TTL_MHZ 40
`define STROBE_MIN_GAP 3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** shared/video_dac_pkg.sv ***
// Types shared by the video DAC front end modules.
// Assumes video_dac_defs.svh on the include path.
`include "video_dac_defs.svh"

package video_dac_pkg;

  typedef logic [`CODE_W-1:0] code_t;
  typedef logic [`ADDR_W-1:0] addr_t;

  typedef struct packed {
    logic [`CTRL_W-1:0] ctrl;
    code_t code;
    logic sync_sw;
    logic blank_sw;
    logic conflict;
    logic rate;
    logic [`COUNT_W-1:0] count;
    logic aw_ok;
    addr_t aw_addr;
    logic w_ok;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } top_state_t;

endpackage

// *** core/pin_sync.sv ***
// Two-stage synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to sys_clk.
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins and synchronised copy
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  initial
  begin
    if (WIDTH < 1)
      $error("pin_sync needs WIDTH of at least 1");
  end

  always_comb
  begin
    state_next.meta = pin_in;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_reg <= '{meta: RST_VAL, stable: RST_VAL};
    else
      state_reg <= state_next;
  end

  assign pin_sync_out = state_reg.stable;

endmodule

// *** core/strobe_edge.sv ***
// Rising-edge detector for the synchronised sample strobe, with spacing check.
// Assumes strobe_s already passed a two-stage synchroniser.
`timescale 1ns/1ps
`include "video_dac_defs.svh"

module strobe_edge #(
  parameter int MIN_GAP = `STROBE_MIN_GAP
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Strobe level in, events out
  input wire logic strobe_s,
  output logic rise,
  output logic too_fast
);

  typedef struct packed {
    logic prev;
    logic seen;
    logic [7:0] gap;
    logic rise;
    logic too_fast;
  } edge_state_t;

  edge_state_t state_reg;
  edge_state_t state_next;

  initial
  begin
    if (MIN_GAP < 2 || MIN_GAP > 255)
      $error("strobe_edge needs MIN_GAP between 2 and 255");
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.prev = strobe_s;
    state_next.rise = strobe_s && !state_reg.prev;
    state_next.too_fast = 1'b0;
    if (state_next.rise)
    begin
      // Edges closer than the sampler can resolve
      state_next.too_fast = state_reg.seen && (state_reg.gap < 8'(MIN_GAP - 1));
      state_next.seen = 1'b1;
      state_next.gap = 8'h00;
    end
    else if (state_reg.gap != 8'hff)
      state_next.gap = state_reg.gap + 8'h01;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_reg <= '{prev: 1'b0, seen: 1'b0, gap: 8'h00, rise: 1'b0, too_fast: 1'b0};
    else
      state_reg <= state_next;
  end

  assign rise = state_reg.rise;
  assign too_fast = state_reg.too_fast;

endmodule

// *** core/video_dac_input_register.sv ***
// Input register and override logic of an 8-bit video D/A converter, AXI4-Lite slave.
// Assumes data, strobe and override pins arrive asynchronously to sys_clk.
//
// Behaviour
// - Sample captured on rising strobe edge
// - Eight flip-flops, one per current switch
// - All ones: switches off, zero volts
// - All zeros: all switches on, full scale
// - White override sets every register bit unless sync/blanking asserted
// - Sync or blanking clears every register bit
// - Sync/blanking switch added while asserted
// - Plain variant: set and reset inputs
// - Strobe rate bounded, 100/40 MHz builds
// - 256 gray levels plus separate sync/blank
// - White override input is active low
// - Sync and blanking inputs active low
`timescale 1ns/1ps
`include "video_dac_defs.svh"

module video_dac_input_register
  import video_dac_pkg::*;
#(
  parameter int MIN_GAP = `STROBE_MIN_GAP
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Sample pins
  input wire video_dac_pkg::code_t sample_in,
  input wire logic strobe_in,
  // Composite variant overrides
  input wire logic white_n,
  input wire logic sync_n,
  input wire logic blank_n,
  // Plain variant overrides
  input wire logic set_in,
  input wire logic reset_in,
  // Current switch drives
  output video_dac_pkg::code_t switch_code,
  output logic sync_switch,
  output logic blank_switch,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire video_dac_pkg::addr_t awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire video_dac_pkg::addr_t araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);

  import video_dac_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic is_mapped(input addr_t a);
    is_mapped = (a == `OFS_CTRL) || (a == `OFS_SAMPLE) ||
                (a == `OFS_STATUS) || (a == `OFS_COUNT);
  endfunction

  function automatic logic [31:0] read_word(input addr_t a, input top_state_t s,
                                            input logic ovr);
    read_word = 32'h0000_0000;
    unique case (a)
      `OFS_CTRL: read_word[`CTRL_W-1:0] = s.ctrl;
      `OFS_SAMPLE: read_word[`CODE_W-1:0] = s.code;
      `OFS_STATUS:
      begin
        read_word[`CODE_W-1:0] = s.code;
        read_word[`ST_SYNC] = s.sync_sw;
        read_word[`ST_BLANK] = s.blank_sw;
        read_word[`ST_OVERRIDE] = ovr;
        read_word[`ST_CONFLICT] = s.conflict;
        read_word[`ST_RATE] = s.rate;
      end
      `OFS_COUNT: read_word[`COUNT_W-1:0] = s.count;
      default: read_word = 32'h0000_0000;
    endcase
  endfunction

  initial
  begin
    if (MIN_GAP < 2 || MIN_GAP > 255)
      $error("MIN_GAP must lie between 2 and 255");
  end

  // ---------------------------------------------------------------
  // Pin synchronisers and strobe edge
  // ---------------------------------------------------------------
  code_t sample_s;
  logic [5:0] ctl_s;
  logic strobe_rise;
  logic strobe_fast;

  pin_sync #(
    .WIDTH(`CODE_W + 6),
    .RST_VAL({8'h00, 6'h1c})
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in({sample_in, strobe_in, white_n, sync_n, blank_n, set_in, reset_in}),
    .pin_sync_out({sample_s, ctl_s})
  );

  strobe_edge #(
    .MIN_GAP(MIN_GAP)
  ) u_strobe_edge (
    .sys_clk(sys_clk),
    .rst(rst),
    .strobe_s(ctl_s[5]),
    .rise(strobe_rise),
    .too_fast(strobe_fast)
  );

  // ---------------------------------------------------------------
  // Override decode
  // ---------------------------------------------------------------
  top_state_t r;
  top_state_t n;
  logic composite;
  logic white_act;
  logic sync_act;
  logic blank_act;
  logic set_act;
  logic clr_act;
  logic override;
  logic wr_fire;

  assign composite = r.ctrl[`CTRL_COMPOSITE];
  assign white_act = composite && (!ctl_s[4] || r.ctrl[`CTRL_WHITE]);
  assign sync_act = composite && (!ctl_s[3] || r.ctrl[`CTRL_SYNC]);
  assign blank_act = composite && (!ctl_s[2] || r.ctrl[`CTRL_BLANK]);
  assign set_act = !composite && (ctl_s[1] || r.ctrl[`CTRL_SET]);
  assign clr_act = sync_act || blank_act ||
                   (!composite && (ctl_s[0] || r.ctrl[`CTRL_RESET]));
  assign override = white_act || set_act || clr_act;
  assign wr_fire = r.aw_ok && r.w_ok && !r.bvalid;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    n = r;

    // Write address and data taken in either order
    if (r.awready && awvalid)
    begin
      n.aw_ok = 1'b1;
      n.aw_addr = awaddr;
    end
    if (r.wready && wvalid)
    begin
      n.w_ok = 1'b1;
      n.w_data = wdata;
      n.w_strb = wstrb;
    end
    if (r.bvalid && bready)
      n.bvalid = 1'b0;
    if (wr_fire)
    begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = is_mapped(r.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      if (r.aw_addr == `OFS_CTRL && r.w_strb[0])
        n.ctrl = r.w_data[`CTRL_W-1:0];
      if (r.aw_addr == `OFS_STATUS && r.w_strb[1])
      begin
        if (r.w_data[`ST_CONFLICT])
          n.conflict = 1'b0;
        if (r.w_data[`ST_RATE])
          n.rate = 1'b0;
      end
    end
    n.awready = !n.aw_ok && !n.bvalid;
    n.wready = !n.w_ok && !n.bvalid;

    // Read channel, one outstanding
    if (r.rvalid && rready)
      n.rvalid = 1'b0;
    if (r.arready && arvalid)
    begin
      n.rvalid = 1'b1;
      n.rdata = read_word(araddr, r, override);
      n.rresp = is_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    n.arready = !n.rvalid;

    // Input register: eight flip-flops feeding the switches
    if (clr_act)
      n.code = `CODE_FULL;
    else if (white_act || set_act)
      n.code = `CODE_WHITE;
    else if (strobe_rise)
    begin
      n.code = sample_s;
      n.count = r.count + `COUNT_W'(1);
    end
    else if (wr_fire && r.aw_addr == `OFS_SAMPLE && r.w_strb[0] &&
             r.ctrl[`CTRL_SW_LOAD])
      n.code = r.w_data[`CODE_W-1:0];
    // Otherwise the register holds, forced value included

    // Separate level switches, no gray code used
    n.sync_sw = sync_act;
    n.blank_sw = blank_act;

    // Sticky flags; a new event beats a clear
    if (white_act && (sync_act || blank_act))
      n.conflict = 1'b1;
    if (strobe_fast)
      n.rate = 1'b1;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      r <= '0;
      r.ctrl <= `CTRL_RST_VAL;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end
    else
      r <= n;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign switch_code = r.code;
  assign sync_switch = r.sync_sw;
  assign blank_switch = r.blank_sw;
  assign awready = r.awready;
  assign wready = r.wready;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = r.arready;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign rresp = r.rresp;

endmodule

// *** verif/video_src.sv ***
// Model of the video source and sync/blanking timing generator.
// Assumes the bench calls its tasks from one process, just after a sys_clk edge.
`timescale 1ns/1ps

module video_src (
  // Clock
  input wire logic sys_clk,
  // Pins toward the converter
  output video_dac_pkg::code_t sample_in,
  output logic strobe_in,
  output logic white_n,
  output logic sync_n,
  output logic blank_n
);
  import video_dac_pkg::*;
  initial
  begin
    sample_in = 8'h5a;
    strobe_in = 1'b0;
    white_n = 1'b1;
    sync_n = 1'b1;
    blank_n = 1'b1;
  end
  // Data scrambled once hold has run out
  task automatic send(input code_t d, input int gap);
    sample_in <= d;
    @(posedge sys_clk);
    strobe_in <= 1'b1;
    repeat (4) @(posedge sys_clk);
    strobe_in <= 1'b0;
    sample_in <= ~d;
    repeat (gap) @(posedge sys_clk);
  endtask
  // White kept off during sync or blanking
  task automatic drive(input logic w, input logic s, input logic b);
    white_n <= !(w && !s && !b);
    sync_n <= !s;
    blank_n <= !b;
  endtask
endmodule

// *** verif/video_dac_input_register_asserts.sv ***
// Assertions on the pin side of the video DAC input register.
// Assumes composite mode for white/sync/blank and no software overrides.
`timescale 1ns/1ps

module video_dac_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins
  input wire video_dac_pkg::code_t sample_in,
  input wire logic strobe_in,
  input wire logic white_n,
  input wire logic sync_n,
  input wire logic blank_n,
  input wire logic set_in,
  input wire logic reset_in,
  // Switch drives
  input wire video_dac_pkg::code_t switch_code,
  input wire logic sync_switch,
  input wire logic blank_switch
);
  import video_dac_pkg::*;
  logic [5:0] stb_h;
  logic [5:0] ovr_h;
  code_t cap_d;
  logic no_ovr;
  assign no_ovr = white_n && sync_n && blank_n && !set_in && !reset_in;
  always_ff @(posedge sys_clk)
  begin
    stb_h <= {stb_h[4:0], strobe_in};
    ovr_h <= {ovr_h[4:0], !no_ovr};
    if (strobe_in && !stb_h[0])
    begin
      cap_d <= sample_in;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_capture;
    $rose(strobe_in) && no_ovr && ovr_h == 6'h00 |-> ##[3:5] switch_code == cap_d;
  endproperty
  a_capture: assert property (p_capture) else $error("sample not captured");
  property p_hold;
    !$stable(switch_code) |-> (|(stb_h[4:0] & ~stb_h[5:1])) || (|ovr_h);
  endproperty
  a_hold: assert property (p_hold) else $error("code changed without cause");
  property p_white;
    (!white_n && sync_n && blank_n)[*5] |-> switch_code == 8'hff;
  endproperty
  a_white: assert property (p_white) else $error("white did not set code");
  property p_clear;
    (!sync_n || !blank_n)[*5] |-> switch_code == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("sync/blank did not clear");
  property p_sync_on;
    (!sync_n)[*5] |-> sync_switch;
  endproperty
  a_sync_on: assert property (p_sync_on) else $error("sync switch off");
  property p_blank_on;
    (!blank_n)[*5] |-> blank_switch;
  endproperty
  a_blank_on: assert property (p_blank_on) else $error("blank switch off");
  property p_sync_cause;
    sync_switch |-> !$past(sync_n, 2) || !$past(sync_n, 3) || !$past(sync_n, 4);
  endproperty
  a_sync_cause: assert property (p_sync_cause) else $error("stray sync switch");
  property p_blank_cause;
    blank_switch |-> !$past(blank_n, 2) || !$past(blank_n, 3) || !$past(blank_n, 4);
  endproperty
  a_blank_cause: assert property (p_blank_cause) else $error("stray blank switch");
  c_strobe: cover property ($rose(strobe_in));
  c_sync: cover property (sync_switch && switch_code == 8'h00);
  c_white: cover property ((!white_n)[*5]);
endmodule

bind video_dac_input_register video_dac_chk chk (.sys_clk(sys_clk), .rst(rst),
  .sample_in(sample_in), .strobe_in(strobe_in), .white_n(white_n), .sync_n(sync_n),
  .blank_n(blank_n), .set_in(set_in), .reset_in(reset_in), .switch_code(switch_code),
  .sync_switch(sync_switch), .blank_switch(blank_switch));

// *** verif/testbench.sv ***
// Self-checking bench for the video DAC input register.
// Assumes video_src drives the sample, strobe, white, sync and blank pins; bench drives set/reset and speaks AXI4-Lite.
`timescale 1ns/1ps
`include "video_dac_defs.svh"

module testbench;
  import video_dac_pkg::*;
  localparam logic [4:0] W_T = 5'b10001;
  localparam logic [4:0] S_T = 5'b11010;
  localparam logic [4:0] B_T = 5'b01100;
  logic sys_clk = 1'b0, rst = 1'b1, set_in = 1'b0, reset_in = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  addr_t awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic awready, wready, bvalid, arready, rvalid, strobe_in, white_n, sync_n, blank_n;
  logic sync_switch, blank_switch;
  logic [1:0] bresp, rresp, r;
  code_t sample_in, switch_code, d;
  int n_fail = 0, checked = 0, n_cap = 0, seed = 32'h6b79;

  always #50 sys_clk = ~sys_clk;

  video_src src (.sys_clk(sys_clk), .sample_in(sample_in), .strobe_in(strobe_in),
    .white_n(white_n), .sync_n(sync_n), .blank_n(blank_n));
  video_dac_input_register #(.MIN_GAP(8)) uut (.sys_clk(sys_clk), .rst(rst),
    .sample_in(sample_in), .strobe_in(strobe_in), .white_n(white_n), .sync_n(sync_n),
    .blank_n(blank_n), .set_in(set_in), .reset_in(reset_in), .switch_code(switch_code),
    .sync_switch(sync_switch), .blank_switch(blank_switch), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input addr_t a, input logic [31:0] v, output logic [1:0] rsp);
    logic ta = 1'b0;
    logic tw = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw))
    begin
      @(posedge sys_clk);
      if (awvalid && awready)
      begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input addr_t a, output logic [31:0] v, output logic [1:0] rsp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (!rvalid);
    v = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rchk(input addr_t a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0] rs;
    rd(a, v, rs);
    chk(v, e);
    chk(32'(rs), 32'(er));
  endtask
  function automatic code_t exp_code(input code_t c, input logic w, input logic s,
                                     input logic b);
    if (s || b)
      return 8'h00;
    return w ? 8'hff : c;
  endfunction
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    wrap_up;
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rchk(`OFS_CTRL, 32'(`CTRL_RST_VAL), `RESP_OKAY);
    rchk(4'h2, 32'h0, `RESP_SLVERR);
    wr(4'h2, 32'hffffffff, r);
    chk(32'(r), 32'(`RESP_SLVERR));
    for (int i = 0; i < 24; i++)
    begin
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      src.send(d, 6);
      n_cap++;
      chk(32'(switch_code), 32'(exp_code(d, 1'b0, 1'b0, 1'b0)));
    end
    for (int k = 0; k < 5; k++)
    begin
      src.drive(W_T[k], S_T[k], B_T[k]);
      repeat (6) @(posedge sys_clk);
      d = 8'($random(seed));
      src.send(d, 6);
      chk(32'({sync_switch, blank_switch, switch_code}),
          32'({S_T[k], B_T[k], exp_code(d, W_T[k], S_T[k], B_T[k])}));
      src.drive(1'b0, 1'b0, 1'b0);
      repeat (6) @(posedge sys_clk);
      chk(32'({sync_switch, blank_switch, switch_code}),
          32'(exp_code(d, W_T[k], S_T[k], B_T[k])));
    end
    rchk(`OFS_COUNT, 32'(n_cap), `RESP_OKAY);
    src.send(8'h3c, 1);
    src.send(8'hc3, 6);
    chk(32'(switch_code), 32'h000000c3);
    rd(`OFS_STATUS, q, r);
    chk(32'(q[12]), 32'h1);
    wr(`OFS_STATUS, 32'h1000, r);
    rchk(`OFS_STATUS, 32'h000000c3, `RESP_OKAY);
    wr(`OFS_CTRL, 32'h0, r);
    set_in <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk(32'(switch_code), 32'hff);
    reset_in <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk(32'(switch_code), 32'h00);
    set_in <= 1'b0;
    reset_in <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rchk(`OFS_CTRL, 32'(`CTRL_RST_VAL), `RESP_OKAY);
    wrap_up;
  end
endmodule
